// >>> verilog/dram_ctrl_pkg.sv
// Constants, commands and states of the SODIMM DRAM controller.
// Assumes one core clock; times are converted at CLK_PERIOD_NS.
package dram_ctrl_pkg;
  localparam int CLK_PERIOD_NS = 100;
  // Refresh interval in ns; longest time, so rounded down
  localparam int REF_NORMAL_NS = 15600;
  localparam logic [11:0] REF_NORMAL_CYC =
    12'(REF_NORMAL_NS / CLK_PERIOD_NS);
  // Device least times in ns, rounded up to cycles
  localparam int TRP_NS  = 20;
  localparam int TRCD_NS = 20;
  localparam int TRAS_NS = 45;
  localparam int TRFC_NS = 70;
  localparam int TMRD_NS = 20;
  localparam logic [3:0] TRP_CYC  =
    4'((TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] TRCD_CYC =
    4'((TRCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] TRAS_CYC =
    4'((TRAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] TRFC_CYC =
    4'((TRFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] TMRD_CYC =
    4'((TMRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] CAS_LAT = 4'h2;
  // Row boundary unit is 8 Mbyte: byte address bit 23 upward
  localparam int UNIT_LSB = 23;
  localparam int AP_BIT   = 10;
  // Copy two: bits 13 and 10 true polarity, rest inverted
  localparam logic [13:0] ADDR_TWO_INV = 14'h1BFF;
  // Mode word: latency two, burst of one
  localparam logic [13:0] MODE_WORD = 14'h0020;
  // {row strobe, column strobe, write enable}, active low
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_MRS = 3'h0;
  typedef enum logic [3:0] {
    S_INIT_PRE, S_INIT_MRS, S_IDLE, S_PREALL, S_REF, S_PRE,
    S_ACT, S_ACCESS, S_RDWAIT, S_RMW, S_FIN, S_WAIT
  } state_e;
endpackage

// >>> verilog/sodimm_dram_controller.sv
// SDRAM/EDO main memory controller: request port to 72-bit array.
// Assumes memory data returns synchronous to CORE_CLK_I.
`timescale 1ns/10ps
module sodimm_dram_controller
  import dram_ctrl_pkg::*;
#(
  parameter int ROWS = 8
)
(
  input  wire logic                CORE_CLK_I,
  input  wire logic                SYS_RST_I,
  input  wire logic                SDRAM_MODE_I,
  input  wire logic                ECC_EN_I,
  input  wire logic                PAGE_OPEN_I,
  input  wire logic [11:0]         REFRESH_INTERVAL_I,
  input  wire logic [1:0]          RAS_TO_CAS_I,
  input  wire logic [1:0]          CAS_WIDTH_I,
  input  wire logic [8*ROWS-1:0]   ROW_BOUND_I,
  input  wire logic [ROWS-1:0]     ROW_64M_I,
  input  wire logic [ROWS-1:0]     ROW_COL9_I,
  input  wire logic                REQ_VALID_I,
  output wire logic                REQ_READY_O,
  input  wire logic                REQ_WRITE_I,
  input  wire logic [27:0]         REQ_ADDR_I,
  input  wire logic [7:0]          REQ_BE_I,
  input  wire logic [63:0]         REQ_WDATA_I,
  output wire logic                RSP_VALID_O,
  output wire logic                RSP_ERR_O,
  output wire logic [63:0]         RSP_RDATA_O,
  output wire logic                ECC_FIXED_O,
  output wire logic                ECC_FATAL_O,
  output wire logic [13:0]         MEM_ADDR_COPY_ONE_O,
  output wire logic [13:0]         MEM_ADDR_COPY_TWO_O,
  output wire logic [7:0]          ROW_SELECT_N_COPY_ONE_O,
  output wire logic [7:0]          ROW_SELECT_N_COPY_TWO_O,
  output wire logic                SDRAM_ROW_STROBE_N_O,
  output wire logic                SDRAM_COL_STROBE_N_O,
  output wire logic                WRITE_ENABLE_N_O,
  output wire logic [7:0]          BYTE_MASK_O,
  output wire logic [5:0]          EDO_ROW_STROBE_N_O,
  output wire logic [7:0]          EDO_COL_STROBE_N_O,
  output wire logic [5:0]          CLOCK_ENABLE_O,
  input  wire logic [63:0]         MEM_DATA_I,
  output wire logic [63:0]         MEM_DATA_O,
  output wire logic                MEM_DATA_OE_O,
  input  wire logic [7:0]          MEM_CHECK_BITS_I,
  output wire logic [7:0]          MEM_CHECK_BITS_O,
  output wire logic                MEM_CHECK_BITS_OE_O
);
  typedef struct packed {
    state_e           st;
    state_e           ret;
    logic [3:0]       cnt;
    logic [3:0]       ras_cnt;
    logic [11:0]      ref_cnt;
    logic             ref_pend;
    logic             sdram;
    logic [2:0]       row;
    logic [1:0]       bank;
    logic [11:0]      prow;
    logic [8:0]       col;
    logic             wr;
    logic             rmw;
    logic [7:0]       be;
    logic [63:0]      wdata;
    logic [31:0]      open_v;
    logic [31:0][11:0] open_row;
    logic [7:0]       cs_n;
    logic [2:0]       cmd;
    logic [13:0]      ma;
    logic [7:0]       dqm;
    logic [63:0]      dq;
    logic [7:0]       cb;
    logic             dq_oe;
    logic [5:0]       cke;
    logic             rsp_v;
    logic             rsp_err;
    logic             fixed;
    logic             fatal;
    logic [63:0]      rdata;
  } ctl_s;

  ctl_s s;
  ctl_s n;
  logic hit;

  // Hamming check bits over positions 1..71, bit 7 overall parity
  function automatic logic [7:0] ecc_gen(input logic [63:0] d);
    logic [6:0] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p < 72; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (d[k]) c = c ^ 7'(p);
        k++;
      end
    end
    return {^{d, c}, c};
  endfunction

  function automatic logic [63:0] ecc_fix(input logic [63:0] d,
                                          input logic [6:0] syn);
    logic [63:0] r;
    int k;
    r = d;
    k = 0;
    for (int p = 1; p < 72; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (7'(p) == syn) r[k] = ~d[k];
        k++;
      end
    end
    return r;
  endfunction

  function automatic logic [13:0] bank_bits(input logic is64,
                                            input logic [1:0] b);
    return is64 ? {1'b0, b, 11'h000} : {2'h0, b[0], 11'h000};
  endfunction

  always_comb
  begin
    logic [2:0]  r;
    logic [7:0]  lo;
    logic [7:0]  base;
    logic [24:0] off;
    logic [24:0] rest;
    logic [1:0]  bk;
    logic [11:0] pr;
    logic [8:0]  cl;
    logic [4:0]  idx;
    logic [4:0]  cur;
    logic [7:0]  calc;
    logic [6:0]  syn;
    logic        par;
    logic [63:0] fixd;
    logic        ref_set;
    logic        ref_clr;
    logic        r64;
    n = s;
    r = '0;
    lo = '0;
    base = '0;
    hit = 1'b0;
    ref_set = 1'b0;
    ref_clr = 1'b0;
    // Row decode against cumulative boundaries
    for (int i = 0; i < ROWS; i++)
    begin
      if (!hit)
      begin
        if ({3'h0, REQ_ADDR_I[27:UNIT_LSB]} < ROW_BOUND_I[8*i +: 8])
        begin
          hit = 1'b1;
          r = 3'(i);
          base = lo;
        end
        lo = ROW_BOUND_I[8*i +: 8];
      end
    end
    off = REQ_ADDR_I[27:3] - {base[4:0], 20'h00000};
    rest = ROW_COL9_I[r] ? (off >> 9) : (off >> 8);
    cl = ROW_COL9_I[r] ? off[8:0] : {1'b0, off[7:0]};
    bk = ROW_64M_I[r] ? rest[1:0] : {1'b0, rest[0]};
    pr = ROW_64M_I[r] ? rest[13:2] : {1'b0, rest[11:1]};
    idx = {r, bk};
    cur = {s.row, s.bank};
    r64 = ROW_64M_I[s.row];
    calc = ecc_gen(MEM_DATA_I);
    syn = calc[6:0] ^ MEM_CHECK_BITS_I[6:0];
    par = ^{MEM_DATA_I, MEM_CHECK_BITS_I};
    fixd = (ECC_EN_I && par) ? ecc_fix(MEM_DATA_I, syn) : MEM_DATA_I;

    n.rsp_v = 1'b0;
    n.rsp_err = 1'b0;
    n.fixed = 1'b0;
    n.fatal = 1'b0;
    if (s.ras_cnt != 4'h0) n.ras_cnt = s.ras_cnt - 4'h1;
    if (s.sdram)
    begin
      n.cs_n = '1;
      n.cmd = CMD_NOP;
      n.dqm = '0;
      n.dq_oe = 1'b0;
    end
    if (REFRESH_INTERVAL_I != 12'h000)
    begin
      if (s.ref_cnt >= REFRESH_INTERVAL_I - 12'h001)
      begin
        n.ref_cnt = '0;
        ref_set = 1'b1;
      end
      else
        n.ref_cnt = s.ref_cnt + 12'h001;
    end

    unique case (s.st)
      S_INIT_PRE:
      begin
        n.sdram = SDRAM_MODE_I;
        ref_set = 1'b1;
        if (SDRAM_MODE_I)
        begin
          n.cke = '1;
          n.cs_n = '0;
          n.cmd = CMD_PRE;
          n.ma[AP_BIT] = 1'b1;
          n.st = S_WAIT;
          n.cnt = TRP_CYC;
          n.ret = S_INIT_MRS;
        end
        else
          n.st = S_IDLE;
      end
      S_INIT_MRS:
      begin
        n.cs_n = '0;
        n.cmd = CMD_MRS;
        n.ma = MODE_WORD;
        n.st = S_WAIT;
        n.cnt = TMRD_CYC;
        n.ret = S_IDLE;
      end
      S_WAIT:
      begin
        if (s.cnt <= 4'h1) n.st = s.ret;
        else n.cnt = s.cnt - 4'h1;
      end
      S_IDLE:
      begin
        if (s.ref_pend)
          n.st = (s.sdram && |s.open_v) ? S_PREALL : S_REF;
        else if (REQ_VALID_I && !hit)
        begin
          n.rsp_v = 1'b1;
          n.rsp_err = 1'b1;
        end
        else if (REQ_VALID_I)
        begin
          n.row = r;
          n.bank = bk;
          n.prow = pr;
          n.col = cl;
          n.wr = REQ_WRITE_I;
          n.be = REQ_BE_I;
          n.wdata = REQ_WDATA_I;
          n.rmw = REQ_WRITE_I && ECC_EN_I && (REQ_BE_I != 8'hFF);
          if (s.sdram && s.open_v[idx])
            n.st = (s.open_row[idx] == pr) ? S_ACCESS : S_PRE;
          else
            n.st = S_ACT;
        end
      end
      S_PREALL:
      begin
        if (s.ras_cnt == 4'h0)
        begin
          n.cs_n = '0;
          n.cmd = CMD_PRE;
          n.ma[AP_BIT] = 1'b1;
          n.open_v = '0;
          n.st = S_WAIT;
          n.cnt = TRP_CYC;
          n.ret = S_REF;
        end
      end
      S_REF:
      begin
        ref_clr = 1'b1;
        n.cs_n = '0;
        if (s.sdram) n.cmd = CMD_REF;
        else n.dqm = '0;
        n.st = S_WAIT;
        n.cnt = TRFC_CYC;
        n.ret = S_FIN;
      end
      S_PRE:
      begin
        if (s.ras_cnt == 4'h0)
        begin
          n.cs_n[s.row] = 1'b0;
          n.cmd = CMD_PRE;
          n.ma = bank_bits(r64, s.bank);
          n.open_v[cur] = 1'b0;
          n.st = S_WAIT;
          n.cnt = TRP_CYC;
          n.ret = S_ACT;
        end
      end
      S_ACT:
      begin
        n.cs_n[s.row] = 1'b0;
        n.ma = bank_bits(r64, s.bank) | (r64 ?
          {s.prow[11], 2'h0, s.prow[10:0]} : {3'h0, s.prow[10:0]});
        n.ras_cnt = TRAS_CYC;
        if (s.sdram)
        begin
          n.cmd = CMD_ACT;
          n.open_v[cur] = 1'b1;
          n.open_row[cur] = s.prow;
        end
        n.st = S_WAIT;
        n.cnt = TRCD_CYC + {2'h0, RAS_TO_CAS_I};
        n.ret = S_ACCESS;
      end
      S_ACCESS:
      begin
        n.cs_n[s.row] = 1'b0;
        n.ma = bank_bits(r64, s.bank) | {5'h00, s.col};
        if (s.wr && !s.rmw)
        begin
          n.dqm = ~s.be;
          n.dq = s.wdata;
          n.cb = ecc_gen(s.wdata);
          n.dq_oe = 1'b1;
          n.rsp_v = 1'b1;
          if (s.sdram) n.cmd = CMD_WR;
          else n.cmd[0] = 1'b0;
          n.st = S_WAIT;
          n.cnt = {2'h0, CAS_WIDTH_I} + 4'h1;
          n.ret = S_FIN;
        end
        else
        begin
          n.dqm = '0;
          if (s.sdram) n.cmd = CMD_RD;
          n.st = S_RDWAIT;
          n.cnt = s.sdram ? CAS_LAT : {2'h0, CAS_WIDTH_I} + 4'h1;
        end
      end
      S_RDWAIT:
      begin
        if (s.cnt != 4'h0)
          n.cnt = s.cnt - 4'h1;
        else
        begin
          n.dqm = '1;
          n.fixed = ECC_EN_I && par;
          n.fatal = ECC_EN_I && !par && (syn != 7'h00);
          n.st = S_FIN;
          if (s.rmw)
          begin
            for (int b = 0; b < 8; b++)
              n.wdata[8*b +: 8] = s.be[b] ? s.wdata[8*b +: 8]
                                          : fixd[8*b +: 8];
            n.st = S_RMW;
          end
          else
          begin
            n.rsp_v = 1'b1;
            n.rdata = fixd;
            if (ECC_EN_I && par)
            begin
              n.wdata = fixd;
              n.st = S_RMW;
            end
          end
        end
      end
      S_RMW:
      begin
        n.cs_n[s.row] = 1'b0;
        n.ma = bank_bits(r64, s.bank) | {5'h00, s.col};
        n.dqm = '0;
        n.dq = s.wdata;
        n.cb = ecc_gen(s.wdata);
        n.dq_oe = 1'b1;
        n.rsp_v = s.wr;
        if (s.sdram) n.cmd = CMD_WR;
        else n.cmd[0] = 1'b0;
        n.st = S_WAIT;
        n.cnt = {2'h0, CAS_WIDTH_I} + 4'h1;
        n.ret = S_FIN;
      end
      S_FIN:
      begin
        if (!s.sdram)
        begin
          n.cs_n = '1;
          n.dqm = '1;
          n.cmd = CMD_NOP;
          n.dq_oe = 1'b0;
          n.st = S_WAIT;
          n.cnt = TRP_CYC;
          n.ret = S_IDLE;
        end
        else if (PAGE_OPEN_I || !s.open_v[cur])
          n.st = S_IDLE;
        else if (s.ras_cnt == 4'h0)
        begin
          n.cs_n[s.row] = 1'b0;
          n.cmd = CMD_PRE;
          n.ma = bank_bits(r64, s.bank);
          n.open_v[cur] = 1'b0;
          n.st = S_WAIT;
          n.cnt = TRP_CYC;
          n.ret = S_IDLE;
        end
      end
    endcase
    n.ref_pend = ref_set | (s.ref_pend & ~ref_clr);
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      s <= '0;
      s.cs_n <= '1;
      s.cmd <= CMD_NOP;
      s.dqm <= '1;
    end
    else
      s <= n;
  end

  assign REQ_READY_O = (s.st == S_IDLE) && !s.ref_pend;
  assign RSP_VALID_O = s.rsp_v;
  assign RSP_ERR_O = s.rsp_err;
  assign RSP_RDATA_O = s.rdata;
  assign ECC_FIXED_O = s.fixed;
  assign ECC_FATAL_O = s.fatal;
  assign MEM_ADDR_COPY_ONE_O = s.ma;
  assign MEM_ADDR_COPY_TWO_O = s.ma ^ ADDR_TWO_INV;
  assign ROW_SELECT_N_COPY_ONE_O = s.cs_n;
  assign ROW_SELECT_N_COPY_TWO_O = s.cs_n;
  assign SDRAM_ROW_STROBE_N_O = s.cmd[2];
  assign SDRAM_COL_STROBE_N_O = s.cmd[1];
  assign WRITE_ENABLE_N_O = s.cmd[0];
  assign BYTE_MASK_O = s.dqm;
  assign EDO_ROW_STROBE_N_O = s.cs_n[5:0];
  assign EDO_COL_STROBE_N_O = s.dqm;
  assign CLOCK_ENABLE_O = s.cke;
  assign MEM_DATA_O = s.dq;
  assign MEM_DATA_OE_O = s.dq_oe;
  assign MEM_CHECK_BITS_O = s.cb;
  assign MEM_CHECK_BITS_OE_O = s.dq_oe;

  default clocking dc @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic live;
  logic rd_cmd;
  logic wr_cmd;
  logic act_cmd;
  logic ref_cmd;
  assign live = s.sdram && !(&s.cs_n);
  assign rd_cmd = live && (s.cmd == CMD_RD);
  assign wr_cmd = live && (s.cmd == CMD_WR);
  assign act_cmd = live && (s.cmd == CMD_ACT);
  assign ref_cmd = live && (s.cmd == CMD_REF);

  chk_read_sample: assert property (
    rd_cmd |-> ##2 (s.st == S_RDWAIT && s.cnt == 4'h0))
    else $error("read data not sampled two clocks after command");
  chk_refresh_closed: assert property (
    ref_cmd |-> s.open_v == '0)
    else $error("refresh issued with a page open");
  chk_refresh_first: assert property (
    s.ref_pend && s.st == S_IDLE |=> s.st inside {S_PREALL, S_REF})
    else $error("pending refresh did not take priority");
  chk_act_closed: assert property (
    s.st == S_ACT |-> !s.open_v[{s.row, s.bank}])
    else $error("activate into a bank with an open page");
  chk_mask_write: assert property (
    wr_cmd && !ECC_EN_I |-> BYTE_MASK_O == ~s.be)
    else $error("byte mask does not match enables");
  chk_rmw_merge: assert property (
    s.sdram && s.st == S_RDWAIT && s.cnt == 4'h0 && s.rmw
    |-> ##2 (wr_cmd && BYTE_MASK_O == 8'h00))
    else $error("merged write did not follow read");
  chk_bank_16m: assert property (
    act_cmd && !ROW_64M_I[s.row] |-> MEM_ADDR_COPY_ONE_O[11] == s.bank[0])
    else $error("16-Mbit bank select wrong");
  chk_bank_64m: assert property (
    act_cmd && ROW_64M_I[s.row] |-> MEM_ADDR_COPY_ONE_O[12:11] == s.bank)
    else $error("64-Mbit bank address wrong");
  chk_one_select: assert property (
    act_cmd |-> $countones(~s.cs_n) == 1)
    else $error("activate selects more than one row");
  cov_read: cover property (rd_cmd ##3 s.rsp_v);
  cov_refresh: cover property (ref_cmd);
  cov_rmw: cover property (s.st == S_RMW && s.rmw);
  cov_page_miss: cover property (s.st == S_PRE);
endmodule

// >>> verification/sdram_model.sv
// Behavioural SDRAM array on the controller's memory pins.
// Assumes latency two; commands sampled on the rising edge.
`timescale 1ns/10ps
module sdram_model
  import dram_ctrl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sd_i,
  input  wire logic        flip_i,
  input  wire logic [7:0]  cs_n_i,
  input  wire logic [2:0]  cmd_i,
  input  wire logic [13:0] addr_i,
  input  wire logic [7:0]  dqm_i,
  input  wire logic [71:0] wd_i,
  input  wire logic        oe_i,
  output logic      [71:0] rd_o,
  output logic      [15:0] viol_o
);
  logic [13:0] row_r [8][4];
  logic [3:0]  open_r [8];
  logic [71:0] mem [logic [27:0]];
  logic        rd_p;
  logic [27:0] key_p;
  logic [27:0] key;
  logic [1:0]  bk;
  logic [71:0] w;

  initial
  begin
    rd_o = 72'h0;
    viol_o = 16'h0;
    rd_p = 1'b0;
    foreach (open_r[i]) open_r[i] = 4'h0;
  end

  always @(posedge clk_i)
  begin
    bk = addr_i[12:11];
    rd_p <= 1'b0;
    // Data only in the cycle before the second edge
    if (rd_p)
      rd_o <= (mem.exists(key_p) ? mem[key_p] : 72'h0) ^ 72'(flip_i);
    else
      rd_o <= ~rd_o;
    for (int i = 0; i < 8; i++)
      if (sd_i && !cs_n_i[i])
      begin
        key = {i[2:0], bk, row_r[i][bk], addr_i[8:0]};
        case (cmd_i)
          CMD_ACT:
          begin
            if (open_r[i][bk]) viol_o <= viol_o + 16'h1;
            open_r[i][bk] = 1'b1;
            row_r[i][bk] = addr_i;
          end
          CMD_PRE:
            if (addr_i[AP_BIT]) open_r[i] = 4'h0;
            else open_r[i][bk] = 1'b0;
          CMD_REF:
            if (open_r[i] != 4'h0) viol_o <= viol_o + 16'h1;
          CMD_RD:
          begin
            if (!open_r[i][bk]) viol_o <= viol_o + 16'h1;
            rd_p <= 1'b1;
            key_p <= key;
          end
          CMD_WR:
          begin
            if (!open_r[i][bk] || !oe_i) viol_o <= viol_o + 16'h1;
            w = mem.exists(key) ? mem[key] : 72'h0;
            for (int b = 0; b < 8; b++)
              if (!dqm_i[b]) w[8*b+:8] = wd_i[8*b+:8];
            w[71:64] = wd_i[71:64];
            mem[key] = w;
          end
          default: ;
        endcase
      end
  end
endmodule

// >>> verification/tb_top.sv
// Self-checking bench of the SODIMM DRAM controller.
// Assumes the SDRAM model answers on the memory pins.
`timescale 1ns/10ps
module tb_top
  import dram_ctrl_pkg::*;
;
  typedef struct packed
  {
    logic        e;
    logic        r;
    logic [63:0] d;
  } exp_s;
  logic        clk = 1'b0, rst = 1'b1, sd = 1'b1, ecc = 1'b0;
  logic        pg = 1'b0, vld = 1'b0, wr = 1'b0, flip = 1'b0;
  logic [11:0] rint = REF_NORMAL_CYC;
  logic [1:0]  rtc = 2'h0, cw = 2'h0;
  logic [27:0] addr = 28'h0;
  logic [7:0]  be = 8'h0;
  logic [63:0] wd = 64'h0;
  logic        rdy, rv, rerr, fix, fat, ras, cas, we, moe, coe;
  logic [63:0] rdata, mdo;
  logic [13:0] ma1, ma2;
  logic [7:0]  cs1, cs2, dqm, ecas, mco;
  logic [5:0]  eras, cke;
  logic [71:0] mrd;
  logic [15:0] viol;
  logic [31:0] seed = 32'h1B1C5457;
  logic [31:0] rn = 32'h0;
  logic [2:0]  cur_row = 3'h0;
  logic [27:0] av [12];
  logic [63:0] ref_m [logic [24:0]];
  exp_s        q [$];
  int          error_cnt = 0, checks = 0;
  int          nref = 0, nfix = 0, nfat = 0, nedo = 0;

  always #50 clk = ~clk;

  sodimm_dram_controller uut
  (
    .CORE_CLK_I(clk), .SYS_RST_I(rst), .SDRAM_MODE_I(sd),
    .ECC_EN_I(ecc), .PAGE_OPEN_I(pg), .REFRESH_INTERVAL_I(rint),
    .RAS_TO_CAS_I(rtc), .CAS_WIDTH_I(cw),
    .ROW_BOUND_I(64'h0404040404040201), .ROW_64M_I(8'h04),
    .ROW_COL9_I(8'h02), .REQ_VALID_I(vld), .REQ_READY_O(rdy),
    .REQ_WRITE_I(wr), .REQ_ADDR_I(addr), .REQ_BE_I(be),
    .REQ_WDATA_I(wd), .RSP_VALID_O(rv), .RSP_ERR_O(rerr),
    .RSP_RDATA_O(rdata), .ECC_FIXED_O(fix), .ECC_FATAL_O(fat),
    .MEM_ADDR_COPY_ONE_O(ma1), .MEM_ADDR_COPY_TWO_O(ma2),
    .ROW_SELECT_N_COPY_ONE_O(cs1), .ROW_SELECT_N_COPY_TWO_O(cs2),
    .SDRAM_ROW_STROBE_N_O(ras), .SDRAM_COL_STROBE_N_O(cas),
    .WRITE_ENABLE_N_O(we), .BYTE_MASK_O(dqm),
    .EDO_ROW_STROBE_N_O(eras), .EDO_COL_STROBE_N_O(ecas),
    .CLOCK_ENABLE_O(cke), .MEM_DATA_I(mrd[63:0]), .MEM_DATA_O(mdo),
    .MEM_DATA_OE_O(moe), .MEM_CHECK_BITS_I(mrd[71:64]),
    .MEM_CHECK_BITS_O(mco), .MEM_CHECK_BITS_OE_O(coe)
  );

  sdram_model mdl
  (
    .clk_i(clk), .sd_i(sd), .flip_i(flip), .cs_n_i(cs1),
    .cmd_i({ras, cas, we}), .addr_i(ma1), .dqm_i(dqm),
    .wd_i({mco, mdo}), .oe_i(moe), .rd_o(mrd), .viol_o(viol)
  );

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic miss(input string m);
    error_cnt++;
    $display("mismatch %0t %s", $time, m);
  endtask

  task automatic cmp_val(input logic [63:0] g, input logic [63:0] e,
                         input string m);
    checks++;
    if (g !== e) miss(m);
  endtask

  task automatic cmp_rsp(input exp_s x);
    cmp_val(64'(rerr), 64'(x.e), "response error flag");
    if (x.r && !x.e) cmp_val(rdata, x.d, "read data");
  endtask

  task automatic final_report();
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One request; the expected answer is queued at the take
  task automatic go(input logic w, input logic [27:0] a,
                    input logic [7:0] b, input logic [63:0] d);
    exp_s x;
    int   n;
    @(posedge clk);
    cur_row = (a[27:23] == 5'h0) ? 3'h0 : (a[27:23] == 5'h1) ? 3'h1 : 3'h2;
    vld <= 1'b1;
    wr <= w;
    addr <= a;
    be <= b;
    wd <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rdy !== 1'b1 && n < 2000);
    vld <= 1'b0;
    if (n >= 2000) miss("request not taken");
    x.e = a[27:23] >= 5'h04;
    x.r = !w;
    x.d = ref_m.exists(a[27:3]) ? ref_m[a[27:3]] : 64'h0;
    if (w && !x.e)
    begin
      for (int i = 0; i < 8; i++)
        if (b[i]) x.d[8*i+:8] = d[8*i+:8];
      ref_m[a[27:3]] = x.d;
    end
    q.push_back(x);
    n = 0;
    while (q.size() != 0 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) miss("no response");
  endtask

  always @(posedge clk)
  begin
    if (!rst)
    begin
      cmp_val(64'(cs2), 64'(cs1), "select copies");
      cmp_val(64'(ma2), 64'(ma1 ^ 14'h1BFF), "address copy two");
      cmp_val(64'(eras), 64'(cs1[5:0]), "edo row strobe");
      cmp_val(64'(ecas), 64'(dqm), "edo column strobe");
      cmp_val(64'(coe), 64'(moe), "check bits enable");
      if (sd && rdy === 1'b1)
        cmp_val(64'(cke), 64'h3F, "clock enable");
      if (sd && {ras, cas, we} === CMD_ACT)
        cmp_val(64'(cs1 ^ (8'h01 << cur_row)), 64'hFF, "row");
      if (sd && cs1 === 8'h00 && {ras, cas, we} === CMD_REF) nref++;
      if (!sd && eras === (6'h3F ^ (6'h01 << cur_row))) nedo++;
      if (fix === 1'b1) nfix++;
      if (fat === 1'b1) nfat++;
      if (rv === 1'b1)
      begin
        if (q.size() == 0) miss("unexpected response");
        else cmp_rsp(q.pop_front());
      end
    end
  end

  initial
  begin
    #(100 * 30000);
    miss("watchdog expired");
    final_report();
  end

  initial
  begin
    void'(rnd());
    @(posedge clk);
    rtc <= seed[1:0];
    cw <= seed[3:2];
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    nref = 0;
    repeat (1000) @(posedge clk);
    cmp_val(64'(nref / 2), 64'(((1000 / REF_NORMAL_CYC) + 1) / 2), "ref");
    rint <= 12'h019;
    for (int i = 0; i < 12; i++)
    begin
      rn = rnd();
      av[i] = {3'h0, rn[24:3], 3'h0};
      go(1'b1, av[i], 8'hFF, {rnd(), rnd()});
    end
    pg <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      go(1'b0, av[i], 8'h00, 64'h0);
      go(1'b0, av[i], 8'h00, 64'h0);
    end
    for (int i = 0; i < 12; i++)
    begin
      rn = rnd();
      go(1'b1, av[i], rn[7:0], {rnd(), rnd()});
      go(1'b0, av[i], 8'h00, 64'h0);
    end
    nref = 0;
    repeat (500) @(posedge clk);
    cmp_val(64'((nref + 1) / 3), 64'h7, "refresh count");
    ecc <= 1'b1;
    for (int i = 0; i < 4; i++)
      go(1'b1, av[i], 8'hFF, {rnd(), rnd()});
    go(1'b1, av[0], 8'h0F, {rnd(), rnd()});
    go(1'b0, av[0], 8'h00, 64'h0);
    flip <= 1'b1;
    go(1'b0, av[1], 8'h00, 64'h0);
    flip <= 1'b0;
    go(1'b0, av[1], 8'h00, 64'h0);
    cmp_val(64'(nfix), 64'h1, "corrections");
    cmp_val(64'(nfat), 64'h0, "fatal errors");
    go(1'b1, 28'hFFFFFF8, 8'hFF, 64'h0);
    go(1'b0, 28'h2000000, 8'h00, 64'h0);
    go(1'b1, 28'h1FFFFF8, 8'hFF, {rnd(), rnd()});
    go(1'b0, 28'h1FFFFF8, 8'h00, 64'h0);
    cmp_val(64'(viol), 64'h0, "memory protocol");
    rst <= 1'b1;
    sd <= 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    go(1'b1, av[2], 8'h3C, {rnd(), rnd()});
    go(1'b1, 28'h2000000, 8'hFF, 64'h0);
    cmp_val(64'(nedo != 0), 64'h1, "edo row strobe use");
    final_report();
  end
endmodule
